// >>> port_one_pkg.sv
package port_one_pkg;

    // ------------------------------------------------------------
    // Register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam int REG_W = 8;
    localparam int MIN_ADDR_W = 4;
    localparam logic [3:0] FSEL_OFFSET = 4'h0;
    localparam logic [3:0] DIR_OFFSET = 4'h4;
    localparam logic [3:0] DATA_OFFSET = 4'h8;
    localparam logic [3:0] PULL_OFFSET = 4'hc;

    // ------------------------------------------------------------
    // Function-select field positions
    // ------------------------------------------------------------
    localparam int FSEL_LINE7_BIT = 7;
    localparam int FSEL_LINE6_BIT = 6;
    localparam int FSEL_LINE5_BIT = 5;
    localparam int FSEL_LINE4_BIT = 4;
    localparam int FSEL_SERIAL2_BIT = 3;
    localparam int FSEL_LINE1_BIT = 2;
    localparam int FSEL_SERIAL1_BIT = 1;
    localparam int FSEL_LINE0_BIT = 0;
    localparam int RESERVED_LINE = 3;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] FSEL_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] PULL_RESET = 8'h00;
    localparam logic [7:0] RESERVED_MASK = 8'h08;
    localparam logic [7:0] LINE_MASK = 8'hf7;
    localparam logic [7:0] ALT_IN_MASK = 8'hf0;
    localparam logic [7:0] ALT_OUT_MASK = 8'h03;
    localparam logic ALT_IN_IDLE = 1'b1;

    // ------------------------------------------------------------
    // Bus answers and states
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [0:0] {WR_COLLECT, WR_RESPOND} wr_state_type;
    typedef enum logic [0:0] {RD_IDLE, RD_RESPOND} rd_state_type;

endpackage

// >>> port_line_drive.sv
`timescale 1ns/1ns
module port_line_drive
    import port_one_pkg::*;
#(
    parameter int WIDTH = 8
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] lineAlt,
    input wire logic [WIDTH-1:0] lineDir,
    input wire logic [WIDTH-1:0] lineData,
    input wire logic [WIDTH-1:0] linePull,
    input wire logic [WIDTH-1:0] altOut,
    output logic [WIDTH-1:0] pinOut,
    output logic [WIDTH-1:0] pinOe,
    output logic [WIDTH-1:0] pinPullUp
);

    typedef struct packed {
        logic [WIDTH-1:0] out;
        logic [WIDTH-1:0] oe;
        logic [WIDTH-1:0] pull;
    } drive_type;

    drive_type s;
    drive_type next_s;

    if (WIDTH != REG_W) begin : g_check
        $error("port_line_drive serves exactly eight lines");
    end

    always_comb begin
        next_s = s;
        for (int i = 0; i < WIDTH; i++) begin
            if (lineAlt[i] && ALT_OUT_MASK[i]) begin
                next_s.oe[i] = 1'b1;
                next_s.out[i] = altOut[i];
            end else if (lineAlt[i]) begin
                next_s.oe[i] = 1'b0;
                next_s.out[i] = 1'b0;
            end else begin
                next_s.oe[i] = lineDir[i];
                next_s.out[i] = lineData[i];
            end
            // Pull-up only ever on a line that is not driven
            next_s.pull[i] = linePull[i] && !next_s.oe[i];
        end
        // Reserved position has no pad behind it
        next_s.out[RESERVED_LINE] = 1'b0;
        next_s.oe[RESERVED_LINE] = 1'b0;
        next_s.pull[RESERVED_LINE] = 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign pinOut = s.out;
    assign pinOe = s.oe;
    assign pinPullUp = s.pull;

endmodule

// >>> alt_input_route.sv
`timescale 1ns/1ns
module alt_input_route
    import port_one_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] lineAlt,
    input wire logic [7:0] pinIn,
    output logic [3:0] extInterrupt,
    output logic timerTriggerInput,
    output logic timerEventInput
);

    typedef struct packed {
        logic [3:0] irq;
        logic trig;
        logic evt;
    } route_type;

    route_type s;
    route_type next_s;

    function automatic logic pass(input logic sel, input logic lvl);
        pass = sel ? lvl : ALT_IN_IDLE;
    endfunction

    always_comb begin
        next_s.irq[3] = pass(lineAlt[FSEL_LINE7_BIT], pinIn[7]);
        next_s.trig = pass(lineAlt[FSEL_LINE7_BIT], pinIn[7]);
        next_s.irq[2] = pass(lineAlt[FSEL_LINE6_BIT], pinIn[6]);
        next_s.irq[1] = pass(lineAlt[FSEL_LINE5_BIT], pinIn[5]);
        next_s.evt = pass(lineAlt[FSEL_LINE5_BIT], pinIn[5]);
        next_s.irq[0] = pass(lineAlt[FSEL_LINE4_BIT], pinIn[4]);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= '1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign extInterrupt = s.irq;
    assign timerTriggerInput = s.trig;
    assign timerEventInput = s.evt;

endmodule

// >>> port_one_gpio_mux.sv
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module port_one_gpio_mux
    import port_one_pkg::*;
#(
    parameter int ADDR_W = 4
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Port one pads
    input wire logic [7:0] portOneIn,
    output logic [7:0] portOneOut,
    output logic [7:0] portOneOe,
    output logic [7:0] portOnePullUp,
    // Port two line 2 and port seven line 2 pads
    input wire logic portTwoLine2GpioOut,
    input wire logic portTwoLine2GpioOe,
    output logic portTwoLine2Out,
    output logic portTwoLine2Oe,
    input wire logic portSevenLine2GpioOut,
    input wire logic portSevenLine2GpioOe,
    output logic portSevenLine2Out,
    output logic portSevenLine2Oe,
    // Peripheral side
    input wire logic pwmOutput,
    input wire logic clockDividerOutput,
    input wire logic firstSerialTx,
    input wire logic secondSerialTx,
    output logic [3:0] extInterrupt,
    output logic timerTriggerInput,
    output logic timerEventInput,
    output logic [7:0] functionSelect
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        wr_state_type wrState;
        rd_state_type rdState;
        logic awready;
        logic wready;
        logic awHeld;
        logic wHeld;
        logic [ADDR_W-1:0] awAddr;
        logic [7:0] wByte;
        logic wLane;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] fsel;
        logic [7:0] dir;
        logic [7:0] data;
        logic [7:0] pull;
        logic p22Out;
        logic p22Oe;
        logic p72Out;
        logic p72Oe;
    } state_type;

    localparam state_type STATE_RESET = '{
        wrState: WR_COLLECT,
        rdState: RD_IDLE,
        awready: 1'b1,
        wready: 1'b1,
        awHeld: 1'b0,
        wHeld: 1'b0,
        awAddr: '0,
        wByte: 8'h00,
        wLane: 1'b0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        arready: 1'b1,
        rvalid: 1'b0,
        rdata: 32'h00000000,
        rresp: RESP_OKAY,
        fsel: FSEL_RESET,
        dir: DIR_RESET,
        data: DATA_RESET,
        pull: PULL_RESET,
        p22Out: 1'b0,
        p22Oe: 1'b0,
        p72Out: 1'b0,
        p72Oe: 1'b0
    };

    state_type s;
    state_type next_s;

    if (ADDR_W < MIN_ADDR_W || ADDR_W > 32) begin : g_check
        $error("ADDR_W must lie between 4 and 32");
    end

    // ------------------------------------------------------------
    // Address decode and readback helpers
    // ------------------------------------------------------------
    // Only the four word slots at the bottom answer; any higher
    // address bit or a misaligned address is refused.
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] hi;
        hi = a >> MIN_ADDR_W;
        mapped = (hi == '0) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [3:0] slot(input logic [ADDR_W-1:0] a);
        slot = a[3:0];
    endfunction

    function automatic logic [7:0] portReadback(
        input logic [7:0] dir,
        input logic [7:0] data,
        input logic [7:0] pins
    );
        logic [7:0] v;
        v = (dir & data)
            | (~dir & pins);
        portReadback = v | RESERVED_MASK;
    endfunction

    function automatic logic [7:0] readValue(
        input state_type st,
        input logic [ADDR_W-1:0] a,
        input logic [7:0] pins
    );
        readValue = 8'h00;
        case (slot(a))
            FSEL_OFFSET: readValue = st.fsel;
            DIR_OFFSET: readValue = 8'h00;
            DATA_OFFSET: readValue = portReadback(st.dir, st.data, pins);
            PULL_OFFSET: readValue = st.pull | RESERVED_MASK;
            default: readValue = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;

        // Address and data are caught separately, in either order
        if (s.awready && s_axi_awvalid) begin
            next_s.awHeld = 1'b1;
            next_s.awAddr = s_axi_awaddr;
            next_s.awready = 1'b0;
        end
        if (s.wready && s_axi_wvalid) begin
            next_s.wHeld = 1'b1;
            next_s.wByte = s_axi_wdata[7:0];
            next_s.wLane = s_axi_wstrb[0];
            next_s.wready = 1'b0;
        end

        case (s.wrState)
            WR_COLLECT: begin
                if (s.awHeld && s.wHeld) begin
                    next_s.awHeld = 1'b0;
                    next_s.wHeld = 1'b0;
                    next_s.bvalid = 1'b1;
                    next_s.wrState = WR_RESPOND;
                    if (!mapped(s.awAddr)) begin
                        next_s.bresp = RESP_SLVERR;
                    end else begin
                        next_s.bresp = RESP_OKAY;
                        // Upper lanes carry nothing, so only lane 0 counts
                        if (s.wLane) begin
                            case (slot(s.awAddr))
                                FSEL_OFFSET: begin
                                    next_s.fsel = s.wByte;
                                end
                                DIR_OFFSET: begin
                                    next_s.dir = s.wByte & LINE_MASK;
                                end
                                DATA_OFFSET: begin
                                    next_s.data = s.wByte & LINE_MASK;
                                end
                                PULL_OFFSET: begin
                                    next_s.pull = s.wByte & LINE_MASK;
                                end
                                default: begin
                                    next_s.bresp = RESP_SLVERR;
                                end
                            endcase
                        end
                    end
                end
            end
            WR_RESPOND: begin
                if (s_axi_bready) begin
                    next_s.bvalid = 1'b0;
                    next_s.awready = 1'b1;
                    next_s.wready = 1'b1;
                    next_s.wrState = WR_COLLECT;
                end
            end
            default: begin
                next_s.wrState = WR_COLLECT;
            end
        endcase

        case (s.rdState)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    // Pins are sampled in the cycle the address is taken
                    next_s.arready = 1'b0;
                    next_s.rvalid = 1'b1;
                    next_s.rdState = RD_RESPOND;
                    next_s.rdata = 32'h00000000;
                    if (mapped(s_axi_araddr)) begin
                        next_s.rdata[7:0] =
                            readValue(s, s_axi_araddr, portOneIn);
                        next_s.rresp = RESP_OKAY;
                    end else begin
                        next_s.rresp = RESP_SLVERR;
                    end
                end
            end
            RD_RESPOND: begin
                if (s_axi_rready) begin
                    next_s.rvalid = 1'b0;
                    next_s.arready = 1'b1;
                    next_s.rdState = RD_IDLE;
                end
            end
            default: begin
                next_s.rdState = RD_IDLE;
            end
        endcase

        // Shared lines of the other ports: the selected transmitter
        // takes the pad, otherwise that port's own logic keeps it
        if (s.fsel[FSEL_SERIAL1_BIT]) begin
            next_s.p22Out = firstSerialTx;
            next_s.p22Oe = 1'b1;
        end else begin
            next_s.p22Out = portTwoLine2GpioOut;
            next_s.p22Oe = portTwoLine2GpioOe;
        end
        if (s.fsel[FSEL_SERIAL2_BIT]) begin
            next_s.p72Out = secondSerialTx;
            next_s.p72Oe = 1'b1;
        end else begin
            next_s.p72Out = portSevenLine2GpioOut;
            next_s.p72Oe = portSevenLine2GpioOe;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= STATE_RESET;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Port one pad drive and alternate inputs
    // ------------------------------------------------------------
    logic [7:0] lineAlt;
    logic [7:0] altOut;

    // Select bits regrouped by the line they steer
    always_comb begin
        lineAlt = 8'h00;
        lineAlt[7] = s.fsel[FSEL_LINE7_BIT];
        lineAlt[6] = s.fsel[FSEL_LINE6_BIT];
        lineAlt[5] = s.fsel[FSEL_LINE5_BIT];
        lineAlt[4] = s.fsel[FSEL_LINE4_BIT];
        lineAlt[1] = s.fsel[FSEL_LINE1_BIT];
        lineAlt[0] = s.fsel[FSEL_LINE0_BIT];
        altOut = 8'h00;
        altOut[1] = pwmOutput;
        altOut[0] = clockDividerOutput;
    end

    port_line_drive #(
        .WIDTH(REG_W)
    ) u_drive (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .lineAlt(lineAlt),
        .lineDir(s.dir),
        .lineData(s.data),
        .linePull(s.pull),
        .altOut(altOut),
        .pinOut(portOneOut),
        .pinOe(portOneOe),
        .pinPullUp(portOnePullUp)
    );

    // Pad levels reach the peripherals one cycle late; cheap, and
    // keeps every output on a flip-flop
    alt_input_route u_route (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .lineAlt(lineAlt),
        .pinIn(portOneIn),
        .extInterrupt(extInterrupt),
        .timerTriggerInput(timerTriggerInput),
        .timerEventInput(timerEventInput)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign portTwoLine2Out = s.p22Out;
    assign portTwoLine2Oe = s.p22Oe;
    assign portSevenLine2Out = s.p72Out;
    assign portSevenLine2Oe = s.p72Oe;
    assign functionSelect = s.fsel;

endmodule

// >>> port_one_gpio_mux_props.sv
`timescale 1ns/1ns
module port_one_gpio_mux_props
    import port_one_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0] portOneIn,
    input wire logic [7:0] portOneOut,
    input wire logic [7:0] portOneOe,
    input wire logic [7:0] portOnePullUp,
    input wire logic portTwoLine2GpioOut,
    input wire logic portTwoLine2GpioOe,
    input wire logic portTwoLine2Out,
    input wire logic portTwoLine2Oe,
    input wire logic portSevenLine2GpioOut,
    input wire logic portSevenLine2GpioOe,
    input wire logic portSevenLine2Out,
    input wire logic portSevenLine2Oe,
    input wire logic pwmOutput,
    input wire logic clockDividerOutput,
    input wire logic firstSerialTx,
    input wire logic secondSerialTx,
    input wire logic [3:0] extInterrupt,
    input wire logic timerTriggerInput,
    input wire logic timerEventInput,
    input wire logic [7:0] functionSelect
);
    // Pads lag one edge, so compare only after a running cycle
    logic live;
    logic [7:0] pSel;
    logic [7:0] pIn;
    logic [3:0] pPer;
    always_ff @(posedge mclk) begin
        live <= ce && !rst;
        pSel <= functionSelect;
        pIn <= portOneIn;
        pPer <= {secondSerialTx, firstSerialTx, pwmOutput, clockDividerOutput};
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_line0;
        live && pSel[0] |-> portOneOe[0] && portOneOut[0] == pPer[0];
    endproperty
    a_line0: assert property (p_line0) else $error("line0 pad");
    property p_line1;
        live && pSel[2] |-> portOneOe[1] && portOneOut[1] == pPer[1];
    endproperty
    a_line1: assert property (p_line1) else $error("line1 pad");
    property p_alt_oe;
        live |-> (portOneOe & {pSel[7:4], 4'h0}) == 8'h00;
    endproperty
    a_alt_oe: assert property (p_alt_oe) else $error("alt oe");
    property p_irq;
        live |-> extInterrupt == (pIn[7:4] | ~pSel[7:4]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq route");
    property p_timer;
        live |-> timerTriggerInput == (pIn[7] | ~pSel[7])
            && timerEventInput == (pIn[5] | ~pSel[5]);
    endproperty
    a_timer: assert property (p_timer) else $error("timer in");
    property p_ser1;
        live |-> portTwoLine2Oe == (pSel[1] | $past(portTwoLine2GpioOe))
            && portTwoLine2Out
            == (pSel[1] ? pPer[2] : $past(portTwoLine2GpioOut));
    endproperty
    a_ser1: assert property (p_ser1) else $error("tx1 pad");
    property p_ser2;
        live |-> portSevenLine2Oe == (pSel[3] | $past(portSevenLine2GpioOe))
            && portSevenLine2Out
            == (pSel[3] ? pPer[3] : $past(portSevenLine2GpioOut));
    endproperty
    a_ser2: assert property (p_ser2) else $error("tx2 pad");
    property p_pull;
        live |-> (portOnePullUp & portOneOe) == 8'h00;
    endproperty
    a_pull: assert property (p_pull) else $error("pull on out");
    property p_rd;
        ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
            && s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer");
endmodule

bind port_one_gpio_mux port_one_gpio_mux_props i_port_one_gpio_mux_props (
    .mclk, .rst, .ce, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rdata, .portOneIn, .portOneOut, .portOneOe, .portOnePullUp,
    .portTwoLine2GpioOut, .portTwoLine2GpioOe, .portTwoLine2Out,
    .portTwoLine2Oe, .portSevenLine2GpioOut, .portSevenLine2GpioOe,
    .portSevenLine2Out, .portSevenLine2Oe, .pwmOutput, .clockDividerOutput,
    .firstSerialTx, .secondSerialTx, .extInterrupt, .timerTriggerInput,
    .timerEventInput, .functionSelect
);

// >>> board_model.sv
`timescale 1ns/1ns
module board_model (
    input wire logic mclk,
    input wire logic [7:0] portOneOut,
    input wire logic [7:0] portOneOe,
    input wire logic [7:0] portOnePullUp,
    input wire logic [7:0] extLevel,
    input wire logic [7:0] extDrive,
    output logic [7:0] portOneIn,
    output logic pwmOutput,
    output logic clockDividerOutput,
    output logic firstSerialTx,
    output logic secondSerialTx,
    output logic [3:0] gpioDrive
);
    logic [7:0] wander = 8'h5a;
    always @(posedge mclk) begin
        wander <= wander + 8'h35;
    end
    // A floating pad must not look like a held level, so it toggles
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (portOneOe[i])
                portOneIn[i] = portOneOut[i];
            else if (extDrive[i])
                portOneIn[i] = extLevel[i];
            else if (portOnePullUp[i])
                portOneIn[i] = 1'b1;
            else
                portOneIn[i] = wander[0] ^ i[0];
        end
    end
    assign {secondSerialTx, firstSerialTx} = wander[2:1];
    assign {pwmOutput, clockDividerOutput} = wander[4:3];
    assign gpioDrive = wander[7:4];
endmodule

// >>> port_one_gpio_mux_tb.sv
`timescale 1ns/1ns
module port_one_gpio_mux_tb import port_one_pkg::*;;
    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, extInterrupt, gpioDrive;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, timerTriggerInput, timerEventInput;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0] portOneIn, portOneOut, portOneOe, portOnePullUp;
    logic [7:0] functionSelect, extLevel = 8'h00, extDrive = 8'h00;
    logic [7:0] dirV, dataV, pullV, selV, lv;
    logic [31:0] r32;
    logic pwmOutput, clockDividerOutput, firstSerialTx, secondSerialTx;
    logic portTwoLine2GpioOut, portTwoLine2GpioOe, portTwoLine2Out;
    logic portTwoLine2Oe, portSevenLine2GpioOut, portSevenLine2GpioOe;
    logic portSevenLine2Out, portSevenLine2Oe;
    int n_mismatch = 0;
    int n_checks = 0;
    localparam logic [4:0] FS = 5'(FSEL_OFFSET);
    localparam logic [4:0] DI = 5'(DIR_OFFSET);
    localparam logic [4:0] DA = 5'(DATA_OFFSET);
    localparam logic [4:0] PU = 5'(PULL_OFFSET);

    always #5 mclk = ~mclk;
    assign {portSevenLine2GpioOe, portSevenLine2GpioOut} = gpioDrive[3:2];
    assign {portTwoLine2GpioOe, portTwoLine2GpioOut} = gpioDrive[1:0];

    port_one_gpio_mux #(.ADDR_W(5)) i_port_one_gpio_mux (.*);
    board_model i_board_model (.mclk, .portOneOut, .portOneOe,
        .portOnePullUp, .extLevel, .extDrive, .portOneIn, .pwmOutput,
        .clockDividerOutput, .firstSerialTx, .secondSerialTx, .gpioDrive);

    // ----------
    // Bus cycles and checks
    // ----------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d,
                      input logic [3:0] s);
        int n;
        bit awOn, wOn;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        awOn = 1'b1;
        wOn = 1'b1;
        rsp = 2'b11;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            if (awOn && s_axi_awready) begin
                awOn = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (wOn && s_axi_wready) begin
                wOn = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                rsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 40) n_mismatch++;
    endtask

    task automatic rd(input logic [4:0] a);
        int n;
        bit arOn;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        arOn = 1'b1;
        rsp = 2'b11;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            if (arOn && s_axi_arready) begin
                arOn = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid) begin
                r32 = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 40) n_mismatch++;
    endtask

    function automatic logic [7:0] rdExp(input logic [7:0] d, v, p);
        return (d & v) | (~d & p) | 8'h08;
    endfunction

    // Alternate outputs force drive; alternate inputs force release
    function automatic logic [7:0] oeExp(input logic [7:0] s, d);
        logic [7:0] o;
        o = d & 8'hf7 & ~{s[7:4], 4'h0};
        o[0] = o[0] | s[0];
        o[1] = o[1] | s[2];
        return o;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        results();
    end

    initial begin
        lv = $urandom(20);
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        extLevel <= lv;
        extDrive <= 8'hff;
        rd(FS);
        chk(r32[7:0], 8'h00);
        rd(DI);
        chk(r32[7:0], 8'h00);
        rd(DA);
        chk(r32[7:0], rdExp(8'h00, 8'h00, lv));
        rd(PU);
        chk(r32[7:0], 8'h08);
        chk({4'h0, extInterrupt}, 8'h0f);
        for (int k = 0; k < 20; k++) begin
            dirV = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
            dataV = 8'($urandom);
            pullV = (k < 2) ? 8'hff : 8'($urandom);
            lv = 8'($urandom);
            extLevel <= lv;
            extDrive <= ~(dirV & 8'hf7);
            wr(DI, dirV, 4'hf);
            wr(DA, dataV, 4'hf);
            wr(PU, pullV, 4'hf);
            rd(DA);
            chk(r32[7:0], rdExp(dirV, dataV, lv));
            rd(PU);
            chk(r32[7:0], pullV | 8'h08);
            rd(DI);
            chk(r32[7:0], 8'h00);
            chk(portOneOe, oeExp(8'h00, dirV));
            chk(portOneOut & dirV & 8'hf7, dataV & dirV & 8'hf7);
            chk(portOnePullUp, pullV & ~dirV & 8'hf7);
        end
        for (int k = 0; k < 12; k++) begin
            selV = (k < 8) ? 8'h01 << k : 8'($urandom);
            dirV = 8'($urandom);
            lv = 8'($urandom);
            extLevel <= lv;
            extDrive <= ~oeExp(selV, dirV);
            wr(DI, dirV, 4'hf);
            wr(FS, selV, 4'hf);
            rd(FS);
            chk(r32[7:0], selV);
            chk(functionSelect, selV);
            chk(portOneOe, oeExp(selV, dirV));
            chk({4'h0, extInterrupt}, (lv | ~selV) >> 4);
            chk({7'h00, portTwoLine2Oe | ~selV[1]}, 8'h01);
            chk({7'h00, portSevenLine2Oe | ~selV[3]}, 8'h01);
        end
        wr(FS, 8'h5a, 4'hf);
        wr(5'h10, 8'hff, 4'hf);
        chk({6'h00, rsp}, {6'h00, RESP_SLVERR});
        wr(5'h02, 8'hff, 4'hf);
        chk({6'h00, rsp}, {6'h00, RESP_SLVERR});
        rd(5'h12);
        chk({6'h00, rsp}, {6'h00, RESP_SLVERR});
        chk(r32[7:0], 8'h00);
        wr(FS, 8'hff, 4'he);
        chk({6'h00, rsp}, {6'h00, RESP_OKAY});
        ce <= 1'b0;
        repeat (3) @(posedge mclk);
        ce <= 1'b1;
        rd(FS);
        chk(r32[7:0], 8'h5a);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(FS);
        chk(r32[7:0], 8'h00);
        results();
    end
endmodule
